// ### hw/lock_pkg.sv
// Package: control codes, status layout and frame carriers for the lock logic
package lock_pkg;
  localparam int CTRL_W = 4;
  localparam int ADDR_W = 12;
  localparam int ADDR_HI_LSB = 4;
  localparam int ADDR_LO_MSB = 3;
  localparam logic [3:0] CTRL_READ_LOCK = 4'h3;
  localparam logic [3:0] CTRL_LOCK_ADDR_HI = 4'h4;
  localparam logic [3:0] CTRL_LOCK_ADDR_LO = 4'h5;
  localparam logic [3:0] CTRL_UNLOCK = 4'h6;
  localparam logic [3:0] CTRL_READ = 4'h7;
  localparam logic [3:0] CTRL_CMD_LOCK = 4'hA;
  localparam logic [3:0] CTRL_WRITE_LOCK = 4'hB;
  localparam logic [3:0] CTRL_CMD = 4'hE;
  localparam logic [3:0] CTRL_WRITE = 4'hF;
  localparam int STAT_LOCK_BIT = 2;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [3:0] ZERO_NIB = 4'h0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  typedef enum logic [2:0] {
    REQ_NONE, REQ_READ, REQ_WRITE, REQ_CMD, REQ_ADDR_HI, REQ_ADDR_LO, REQ_UNLOCK
  } req_e;
  // Header of a frame, given once the control field is complete
  typedef struct packed {
    logic [ADDR_W-1:0] master_addr;
    logic [CTRL_W-1:0] ctrl;
  } frame_hdr_s;
  // Frame end summary
  typedef struct packed {
    logic len_ack_zero;
    logic bytes_short;
    logic over_max;
  } frame_end_s;
endpackage

// ### hw/bus_slave_control_lock_logic.sv
// Slave control field decode and multi-frame lock state
`timescale 1ns/1ps
module bus_slave_control_lock_logic (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Frame header from the link layer
  input wire logic hdr_valid,
  input wire lock_pkg::frame_hdr_s hdr,
  // Received data byte
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  // Byte requested for transmit and buffer contents
  input wire logic tx_req,
  input wire logic [7:0] buf_byte,
  // Frame end with summary
  input wire logic frame_end,
  input wire lock_pkg::frame_end_s end_info,
  // Slave status byte from application, lock bit overridden
  input wire logic [7:0] app_status,
  // Decoded request and acceptance
  output logic [2:0] req_type,
  output logic hdr_accept,
  // Application data path
  output logic app_data_valid,
  output logic app_cmd_valid,
  output logic [7:0] app_byte,
  // Transmit byte
  output logic [7:0] tx_byte,
  // Lock state
  output logic locked,
  output logic [11:0] lock_addr,
  output logic [7:0] slave_status
);
  // Decoded request and frame state
  lock_pkg::req_e req_reg;
  lock_pkg::req_e req_next;
  logic active_reg;
  logic lockable_reg;
  logic lockable_next;
  logic [11:0] cur_addr_reg;

  // Lock state
  logic locked_reg;
  logic [11:0] lock_addr_reg;

  // Application and transmit data
  logic [7:0] app_byte_reg;
  logic app_data_reg;
  logic app_cmd_reg;
  logic [7:0] tx_byte_reg;

  // Qualifiers
  logic addr_ok;
  logic code_known;
  logic take_hdr;
  logic frame_close;
  logic byte_in;
  logic byte_out;
  logic lock_set;
  logic lock_clear;

  // Foreign masters are refused outright while locked
  assign addr_ok = !locked_reg || (hdr.master_addr == lock_addr_reg);
  assign code_known = (req_next != lock_pkg::REQ_NONE);
  assign take_hdr = hdr_valid && addr_ok && code_known;

  // A header wins over a frame end in the same cycle
  assign frame_close = frame_end && !hdr_valid;

  // Bytes of a refused frame never reach the application
  assign byte_in = rx_valid && active_reg;
  assign byte_out = tx_req && active_reg;

  always_comb begin
    unique case (hdr.ctrl)
      lock_pkg::CTRL_READ_LOCK, lock_pkg::CTRL_READ: req_next = lock_pkg::REQ_READ;
      lock_pkg::CTRL_WRITE_LOCK, lock_pkg::CTRL_WRITE: req_next = lock_pkg::REQ_WRITE;
      lock_pkg::CTRL_CMD_LOCK, lock_pkg::CTRL_CMD: req_next = lock_pkg::REQ_CMD;
      lock_pkg::CTRL_LOCK_ADDR_HI: req_next = lock_pkg::REQ_ADDR_HI;
      lock_pkg::CTRL_LOCK_ADDR_LO: req_next = lock_pkg::REQ_ADDR_LO;
      lock_pkg::CTRL_UNLOCK: req_next = lock_pkg::REQ_UNLOCK;
      default: req_next = lock_pkg::REQ_NONE;
    endcase
  end

  // Only the read, command and write lock codes may lock
  always_comb begin
    unique case (hdr.ctrl)
      lock_pkg::CTRL_READ_LOCK, lock_pkg::CTRL_CMD_LOCK, lock_pkg::CTRL_WRITE_LOCK: begin
        lockable_next = 1'b1;
      end
      default: begin
        lockable_next = 1'b0;
      end
    endcase
  end

  // Lock needs all three end conditions; other early endings leave it alone
  assign lock_set = frame_close && active_reg && lockable_reg &&
                    end_info.len_ack_zero && end_info.bytes_short &&
                    end_info.over_max;
  assign lock_clear = frame_close && active_reg &&
                      (req_reg == lock_pkg::REQ_UNLOCK);

  // Request of the running frame; refused headers leave none
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_reg <= lock_pkg::REQ_NONE;
    end else if (hdr_valid) begin
      req_reg <= addr_ok ? req_next : lock_pkg::REQ_NONE;
    end else if (frame_end) begin
      req_reg <= lock_pkg::REQ_NONE;
    end
  end

  // Frame active flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active_reg <= 1'b0;
    end else if (hdr_valid) begin
      active_reg <= take_hdr;
    end else if (frame_end) begin
      active_reg <= 1'b0;
    end
  end

  // Lock capability of the running frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lockable_reg <= 1'b0;
    end else if (hdr_valid) begin
      lockable_reg <= lockable_next;
    end
  end

  // Address of the master of the running frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_addr_reg <= lock_pkg::ADDR_RESET;
    end else if (hdr_valid) begin
      cur_addr_reg <= hdr.master_addr;
    end
  end

  // Lock flag; a cancel only comes from an accepted master
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      locked_reg <= 1'b0;
    end else if (lock_clear) begin
      locked_reg <= 1'b0;
    end else if (lock_set) begin
      locked_reg <= 1'b1;
    end
  end

  // Locking master address, zero while unlocked
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_addr_reg <= lock_pkg::ADDR_RESET;
    end else if (lock_clear) begin
      lock_addr_reg <= lock_pkg::ADDR_RESET;
    end else if (lock_set) begin
      lock_addr_reg <= cur_addr_reg;
    end
  end

  // Data write strobe to the application
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      app_data_reg <= 1'b0;
    end else begin
      app_data_reg <= byte_in && (req_reg == lock_pkg::REQ_WRITE);
    end
  end

  // Command write strobe to the application
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      app_cmd_reg <= 1'b0;
    end else begin
      app_cmd_reg <= byte_in && (req_reg == lock_pkg::REQ_CMD);
    end
  end

  // Last accepted byte, held until the next one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      app_byte_reg <= lock_pkg::ZERO_BYTE;
    end else if (byte_in) begin
      app_byte_reg <= rx_byte;
    end
  end

  // Transmit byte: buffer data or packed locked address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_byte_reg <= lock_pkg::ZERO_BYTE;
    end else if (byte_out) begin
      unique case (req_reg)
        lock_pkg::REQ_READ: begin
          tx_byte_reg <= buf_byte;
        end
        lock_pkg::REQ_ADDR_HI: begin
          tx_byte_reg <= lock_addr_reg[lock_pkg::ADDR_W-1:lock_pkg::ADDR_HI_LSB];
        end
        lock_pkg::REQ_ADDR_LO: begin
          tx_byte_reg <= {lock_addr_reg[lock_pkg::ADDR_LO_MSB:0], lock_pkg::ZERO_NIB};
        end
        default: begin
          tx_byte_reg <= lock_pkg::ZERO_BYTE;
        end
      endcase
    end
  end

  // Application owns every status bit but the lock bit
  always_comb begin
    slave_status = app_status;
    slave_status[lock_pkg::STAT_LOCK_BIT] = locked_reg;
  end

  assign req_type = req_reg;
  assign hdr_accept = take_hdr;
  assign app_data_valid = app_data_reg;
  assign app_cmd_valid = app_cmd_reg;
  assign app_byte = app_byte_reg;
  assign tx_byte = tx_byte_reg;
  assign locked = locked_reg;
  assign lock_addr = lock_addr_reg;
endmodule // bus_slave_control_lock_logic

// ### bench/lock_sva.sv
// Lock logic checker
`timescale 1ns/1ps
module lock_sva (
  input wire logic clk, rst_n, hdr_valid, tx_req, rx_valid, frame_end, hdr_accept,
  input wire logic app_data_valid, app_cmd_valid, locked,
  input wire lock_pkg::frame_hdr_s hdr,
  input wire lock_pkg::frame_end_s end_info,
  input wire logic [7:0] buf_byte, app_status, tx_byte, slave_status,
  input wire logic [2:0] req_type,
  input wire logic [11:0] lock_addr
);
  lock_pkg::frame_hdr_s h_reg;
  // Accepted header only, so refused frames cannot move the lock
  always_ff @(posedge clk) if (hdr_valid && hdr_accept) h_reg <= hdr;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_lock;
    frame_end && !hdr_valid && (&end_info) ##0 h_reg.ctrl inside {4'h3, 4'hA, 4'hB};
  endsequence
  AST_READ: assert property (tx_req && req_type == 3'h1 |=> tx_byte == $past(buf_byte))
    else $error("read byte");
  AST_WRITE: assert property (rx_valid && req_type == 3'h2 |=> app_data_valid)
    else $error("write valid");
  AST_ADDR_HI: assert property (tx_req && req_type == 3'h4 |=> tx_byte == lock_addr[11:4])
    else $error("lock address");
  AST_ADDR_LO: assert property (tx_req && req_type == 3'h5 |=>
    tx_byte == {lock_addr[3:0], 4'h0}) else $error("lock address low");
  AST_CMD: assert property (rx_valid && req_type == 3'h3 |=> app_cmd_valid)
    else $error("command valid");
  AST_UNLOCK: assert property (frame_end && !hdr_valid && h_reg.ctrl == 4'h6 |=>
    !locked && lock_addr == 12'h000) else $error("unlock");
  AST_REFUSE: assert property (locked && hdr_valid && hdr.master_addr != lock_addr |->
    !hdr_accept ##1 locked) else $error("refuse");
  AST_LOCK: assert property (s_lock |=>
    locked && lock_addr == $past(h_reg.master_addr)) else $error("lock");
  AST_STATUS: assert property (
    slave_status == {app_status[7:3], locked, app_status[1:0]}) else $error("status");
  AST_NO_LOCK: assert property (frame_end && !end_info.over_max && !locked |=> !locked)
    else $error("early lock");
endmodule // lock_sva
bind bus_slave_control_lock_logic lock_sva chk (.*);

// ### bench/master_model.sv
// Remote master model, one frame at a time
`timescale 1ns/1ps
module master_model (
  input wire logic clk,
  output logic hdr_valid, rx_valid, tx_req, frame_end,
  output lock_pkg::frame_hdr_s hdr,
  output lock_pkg::frame_end_s end_info,
  output logic [7:0] rx_byte
);
  initial {hdr_valid, rx_valid, tx_req, frame_end, hdr, end_info, rx_byte} = '0;
  // Write and command codes (c[3] set) send a[7:0], others fetch; released byte line shows its inverse
  task automatic frame(input logic [11:0] a, input logic [3:0] c, input logic [2:0] e);
    @(negedge clk) {hdr_valid, hdr} = {1'b1, a, c};
    @(negedge clk) {hdr_valid, rx_valid, tx_req, rx_byte} = {1'b0, c[3], !c[3], a[7:0]};
    @(negedge clk) {rx_valid, tx_req, rx_byte, frame_end, end_info} = {2'b00, ~a[7:0], 1'b1, e};
    @(negedge clk) {frame_end, end_info} = 4'h0;
  endtask
endmodule // master_model

// ### bench/test_bus_slave_control_lock_logic.sv
// Testbench for the lock logic
`timescale 1ns/1ps
`define CK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH %0t %h %h", $time, (a), (b)); end end
module test_bus_slave_control_lock_logic;
  logic clk = 1'b0, rst_n = 1'b0, hdr_valid, rx_valid, tx_req, frame_end, hdr_accept, locked;
  logic app_data_valid, app_cmd_valid;
  logic [7:0] buf_byte = 8'h5A, app_status = 8'hFF, rx_byte, app_byte, tx_byte, slave_status;
  logic [2:0] req_type;
  logic [11:0] lock_addr;
  lock_pkg::frame_hdr_s hdr;
  lock_pkg::frame_end_s end_info;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  master_model m (.*);
  bus_slave_control_lock_logic dut (.*);
  always @(posedge clk) if (++cyc > 3000) begin
    error_cnt++;
    end_sim();
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_plain();
    m.frame(12'h123, 4'h7, 3'h7);
    `CK({tx_byte, locked}, 9'h0B4)
    m.frame(12'h1C3, 4'hF, 3'h7);
    `CK({app_byte, locked}, 9'h186)
    m.frame(12'h13C, 4'hE, 3'h7);
    `CK(app_byte, 8'h3C)
    $display("plain frames done");
  endtask
  task automatic t_nolock();
    logic [2:0] e[3] = '{3'h3, 3'h5, 3'h6};
    foreach (e[i]) begin
      m.frame(12'h0F0, 4'hB, e[i]);
      `CK(locked, 1'b0)
    end
    $display("no-lock frames done");
  endtask
  task automatic t_lock();
    logic [3:0] c[3] = '{4'h3, 4'hA, 4'hB};
    foreach (c[i]) begin
      m.frame(12'hABC, c[i], 3'h7);
      `CK({locked, lock_addr, slave_status}, {1'b1, 12'hABC, 8'hFF})
      m.frame(12'h399, 4'hF, 3'h7);
      `CK({locked, app_byte == 8'h99}, 2'b10)
      m.frame(12'hABC, 4'h4, 3'h0);
      `CK(tx_byte, 8'hAB)
      m.frame(12'hABC, 4'h5, 3'h0);
      `CK(tx_byte, 8'hC0)
      m.frame(12'hABC, 4'h6, 3'h0);
      `CK({locked, lock_addr, slave_status}, {1'b0, 12'h000, 8'hFB})
    end
    $display("lock frames done");
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    `CK(slave_status, 8'hFB)
    t_plain();
    t_nolock();
    t_lock();
    end_sim();
  end
endmodule // test_bus_slave_control_lock_logic
